// *** logic/sgsc_top.v ***
// Global identity and start control register bank with APB slave.
`timescale 1ns/1ps
`include "sgsc_regs.vh"
module sgsc_top #(
  parameter [7:0] FAMILY_CODE = 8'h5a,
  parameter [3:0] PART_CODE = 4'h7,
  parameter [2:0] REVISION = 3'h1,
  parameter NUM_PORTS = 3,
  parameter [39:0] FAST_AGE_CYCLES = (`SGSC_CLK_HZ / `SGSC_HZ_PER_MHZ) * `SGSC_FAST_AGE_US,
  parameter [39:0] NORMAL_AGE_CYCLES = `SGSC_CLK_HZ * `SGSC_NORMAL_AGE_S,
  parameter CFG_WAIT_CYCLES = 64
) (
  // APB.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Strap pins.
  input wire mode_strap_high,
  input wire mode_strap_low,
  // Configuration memory loader.
  output reg cfg_read_req,
  output reg [7:0] cfg_addr,
  input wire cfg_present,
  input wire cfg_valid,
  input wire [7:0] cfg_data,
  // Link state per port.
  input wire [NUM_PORTS-1:0] link_up,
  // Switch core controls.
  output reg switch_run,
  output reg alt_backoff,
  output reg pass_flow_ctrl,
  output reg fast_age_active,
  output reg age_tick,
  output reg flush_all
);
  // Comments in the family-code and part-code parameters: default values are arbitrary.

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  wire [1:0] straps_s;
  wire [NUM_PORTS-1:0] link_s;
  wire [9:0] cfg_s;
  sgsc_sync #(.WIDTH(2)) u_strap (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({mode_strap_high, mode_strap_low}),
    .sync_out(straps_s)
  );
  sgsc_sync #(.WIDTH(NUM_PORTS)) u_link (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(link_up),
    .sync_out(link_s)
  );
  // The data byte travels with its valid flag, so both arrive on the same edge.
  sgsc_sync #(.WIDTH(10)) u_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({cfg_present, cfg_valid, cfg_data}),
    .sync_out(cfg_s)
  );
  wire cfg_present_s = cfg_s[9];
  wire cfg_valid_s = cfg_s[8];
  wire [7:0] cfg_data_s = cfg_s[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Decode.
  wire [7:0] offset = paddr[9:2];
  wire [3:0] region;
  sgsc_decode u_dec (
    .offset(offset),
    .region(region)
  );
  wire in_range = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'b00);
  wire access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Loader state machine.
  localparam ST_IDLE = 3'd0;
  localparam ST_REQ = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_DONE = 3'd3;
  localparam ST_RUN = 3'd4;
  reg [2:0] state;
  reg [1:0] idx;
  reg [7:0] cfg_b0;
  reg [7:0] cfg_b1;
  reg [15:0] wait_cnt;
  reg [1:0] settle_cnt;
  reg auto_mode;
  reg start_bit;
  reg [7:0] gctl0;
  wire id_match = (cfg_b0 == FAMILY_CODE) && (cfg_b1[7:4] == PART_CODE);

  wire wr_hit = access && pwrite && in_range;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      idx <= 2'd0;
      cfg_b0 <= 8'h00;
      cfg_b1 <= 8'h00;
      wait_cnt <= 16'h0000;
      settle_cnt <= 2'h0;
      auto_mode <= 1'b0;
      cfg_read_req <= 1'b0;
      cfg_addr <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          // Synchronised straps read zero until two edges after reset, so the choice waits.
          if (settle_cnt != `SGSC_SETTLE_EDGES) begin
            settle_cnt <= settle_cnt + 2'h1;
          end else begin
            auto_mode <= (straps_s == 2'b00);
            idx <= 2'd0;
            if (straps_s == 2'b00 && cfg_present_s) begin
              state <= ST_REQ;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_REQ: begin
          // The previous byte's valid still drains through the synchroniser.
          if (!cfg_valid_s) begin
            cfg_read_req <= 1'b1;
            cfg_addr <= {6'h00, idx};
            wait_cnt <= 16'h0000;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt + 16'h0001;
          if (cfg_valid_s) begin
            cfg_read_req <= 1'b0;
            if (idx == 2'd0) begin
              cfg_b0 <= cfg_data_s;
            end else if (idx == 2'd1) begin
              cfg_b1 <= cfg_data_s;
            end
            if (idx == 2'd2) begin
              state <= ST_DONE;
            end else begin
              idx <= idx + 2'd1;
              state <= ST_REQ;
            end
          end else if (wait_cnt == CFG_WAIT_CYCLES[15:0]) begin
            cfg_read_req <= 1'b0;
            cfg_b0 <= 8'h00;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_RUN;
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_bit <= 1'b0;
      gctl0 <= `SGSC_GCTL0_RESET;
    end else begin
      if (state == ST_WAIT && cfg_valid_s && idx == 2'd2 && id_match) begin
        gctl0 <= cfg_data_s;
      end else if (wr_hit && offset == `SGSC_OFF_GCTL0) begin
        gctl0 <= pwdata[7:0];
      end
      if (wr_hit && offset == `SGSC_OFF_PART) begin
        start_bit <= pwdata[`SGSC_BIT_START];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_run <= 1'b0;
      alt_backoff <= 1'b0;
      pass_flow_ctrl <= 1'b0;
    end else begin
      if (state == ST_RUN) begin
        switch_run <= auto_mode ? 1'b1 : start_bit;
      end else begin
        switch_run <= 1'b0;
      end
      alt_backoff <= gctl0[`SGSC_BIT_BACKOFF];
      pass_flow_ctrl <= gctl0[`SGSC_BIT_PASS_FC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Aging control.
  reg [NUM_PORTS-1:0] link_prev;
  reg [39:0] age_cnt;
  wire link_drop = |(link_prev & ~link_s);
  wire [39:0] age_limit = fast_age_active ? FAST_AGE_CYCLES : NORMAL_AGE_CYCLES;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_prev <= {NUM_PORTS{1'b0}};
      age_cnt <= 40'h0;
      fast_age_active <= 1'b0;
      age_tick <= 1'b0;
      flush_all <= 1'b0;
    end else begin
      link_prev <= link_s;
      age_tick <= 1'b0;
      flush_all <= link_drop;
      if (link_drop && gctl0[`SGSC_BIT_LINK_AGE]) begin
        fast_age_active <= 1'b1;
        age_cnt <= 40'h0;
      end else if (age_cnt >= age_limit - 40'h1) begin
        age_cnt <= 40'h0;
        age_tick <= 1'b1;
        fast_age_active <= 1'b0;
      end else begin
        age_cnt <= age_cnt + 40'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (in_range) begin
        case (region)
          `SGSC_RGN_GLOBAL: begin
            case (offset)
              `SGSC_OFF_FAMILY: begin
                prdata <= {24'h0, FAMILY_CODE};
              end
              `SGSC_OFF_PART: begin
                prdata <= {24'h0, PART_CODE, REVISION, start_bit};
              end
              `SGSC_OFF_GCTL0: begin
                prdata <= {24'h0, gctl0};
              end
              default: begin
                prdata <= 32'h0;
              end
            endcase
          end
          // Port, priority, address and indirect registers live outside this bank.
          `SGSC_RGN_P1_CTL, `SGSC_RGN_P1_STA: begin
            prdata <= 32'h0;
          end
          `SGSC_RGN_P2_CTL, `SGSC_RGN_P2_STA: begin
            prdata <= 32'h0;
          end
          `SGSC_RGN_P3_CTL, `SGSC_RGN_P3_STA: begin
            prdata <= 32'h0;
          end
          `SGSC_RGN_TOS, `SGSC_RGN_MAC, `SGSC_RGN_USER: begin
            prdata <= 32'h0;
          end
          `SGSC_RGN_IND_CTL, `SGSC_RGN_IND_DAT, `SGSC_RGN_TEST: begin
            prdata <= 32'h0;
          end
          default: begin
            if (offset == `SGSC_OFF_STATUS) begin
              prdata <= {24'h0, 1'b0, state, fast_age_active, switch_run, straps_s};
            end
          end
        endcase
      end
    end
  end
endmodule

// *** logic/sgsc_regs.vh ***
// Register offsets, field positions, reset values and timing constants.
// What this block does
// - Every register is eight bits wide at a single byte offset.
// - Offsets 0x10-0x1D are port one control, 0x1E-0x1F port one status.
// - Offsets 0x20-0x2D are port two control, 0x2E-0x2F port two status.
// - Offsets 0x30-0x39 port three control, 0x3F its status; others reserved.
// - Service-type priority at 0x60-0x6F, station address at 0x70-0x75.
// - Indirect control 0x79-0x7A, indirect data 0x7B-0x83, test/debug to 0x8D.
// - Offset zero returns a fixed read-only family code.
// - Offset one holds read-only part code and silicon revision.
// - With straps not both low, switch runs only while start bit is one.
// - With straps both low, switch starts itself after trying the memory.
// - With no memory answering, registers keep strap or built-in defaults.
// - Memory contents replace defaults only when the family byte and the part-code nibble match.
// - Offset two bit seven selects alternative back-off, reset zero.
// - Offset two bit three forwards flow-control frames; resets to filtering.
// - With bit zero set, link loss triggers a fast aging period of 800 us.
// - After fast aging, aging returns to the normal period of about 200 s.
// - Unplugging any port ages out all learned addresses.
`ifndef SGSC_REGS_VH
`define SGSC_REGS_VH
`define SGSC_OFF_FAMILY 8'h00
`define SGSC_OFF_PART 8'h01
`define SGSC_OFF_GCTL0 8'h02
`define SGSC_OFF_GLOB_LAST 8'h0f
`define SGSC_OFF_P1_CTL_LO 8'h10
`define SGSC_OFF_P1_CTL_HI 8'h1d
`define SGSC_OFF_P1_STA_LO 8'h1e
`define SGSC_OFF_P1_STA_HI 8'h1f
`define SGSC_OFF_P2_CTL_LO 8'h20
`define SGSC_OFF_P2_CTL_HI 8'h2d
`define SGSC_OFF_P2_STA_LO 8'h2e
`define SGSC_OFF_P2_STA_HI 8'h2f
`define SGSC_OFF_P3_CTL_LO 8'h30
`define SGSC_OFF_P3_CTL_HI 8'h39
`define SGSC_OFF_P3_STA 8'h3f
`define SGSC_OFF_TOS_LO 8'h60
`define SGSC_OFF_TOS_HI 8'h6f
`define SGSC_OFF_MAC_LO 8'h70
`define SGSC_OFF_MAC_HI 8'h75
`define SGSC_OFF_USER_LO 8'h76
`define SGSC_OFF_USER_HI 8'h78
`define SGSC_OFF_IND_CTL_LO 8'h79
`define SGSC_OFF_IND_CTL_HI 8'h7a
`define SGSC_OFF_IND_DAT_LO 8'h7b
`define SGSC_OFF_IND_DAT_HI 8'h83
`define SGSC_OFF_TEST_LO 8'h84
`define SGSC_OFF_TEST_HI 8'h8d
`define SGSC_OFF_STATUS 8'h8e
// Region codes returned by the decoder.
`define SGSC_RGN_NONE 4'h0
`define SGSC_RGN_GLOBAL 4'h1
`define SGSC_RGN_P1_CTL 4'h2
`define SGSC_RGN_P1_STA 4'h3
`define SGSC_RGN_P2_CTL 4'h4
`define SGSC_RGN_P2_STA 4'h5
`define SGSC_RGN_P3_CTL 4'h6
`define SGSC_RGN_P3_STA 4'h7
`define SGSC_RGN_TOS 4'h8
`define SGSC_RGN_MAC 4'h9
`define SGSC_RGN_USER 4'ha
`define SGSC_RGN_IND_CTL 4'hb
`define SGSC_RGN_IND_DAT 4'hc
`define SGSC_RGN_TEST 4'hd
// Field positions.
`define SGSC_BIT_START 0
`define SGSC_BIT_BACKOFF 7
`define SGSC_BIT_PASS_FC 3
`define SGSC_BIT_LINK_AGE 0
// Reset values.
`define SGSC_GCTL0_RESET 8'h44
`define SGSC_PART_MASK 8'hf0
// Timing.
`define SGSC_CLK_HZ 40'h2625a00
`define SGSC_HZ_PER_MHZ 40'hf4240
`define SGSC_FAST_AGE_US 40'h320
`define SGSC_NORMAL_AGE_S 40'hc8
`define SGSC_SETTLE_EDGES 2'h2
`endif

// *** logic/sgsc_decode.v ***
// Address decoder mapping a byte offset to its register region.
`timescale 1ns/1ps
`include "sgsc_regs.vh"
module sgsc_decode (
  // Offset in.
  input wire [7:0] offset,
  // Region out.
  output reg [3:0] region
);
  always @* begin
    region = `SGSC_RGN_NONE;
    if (offset <= `SGSC_OFF_GLOB_LAST) begin
      region = `SGSC_RGN_GLOBAL;
    end else if (offset <= `SGSC_OFF_P1_CTL_HI) begin
      region = `SGSC_RGN_P1_CTL;
    end else if (offset <= `SGSC_OFF_P1_STA_HI) begin
      region = `SGSC_RGN_P1_STA;
    end else if (offset <= `SGSC_OFF_P2_CTL_HI) begin
      region = `SGSC_RGN_P2_CTL;
    end else if (offset <= `SGSC_OFF_P2_STA_HI) begin
      region = `SGSC_RGN_P2_STA;
    end else if (offset <= `SGSC_OFF_P3_CTL_HI) begin
      region = `SGSC_RGN_P3_CTL;
    end else if (offset == `SGSC_OFF_P3_STA) begin
      region = `SGSC_RGN_P3_STA;
    end else if (offset >= `SGSC_OFF_TOS_LO && offset <= `SGSC_OFF_TOS_HI) begin
      region = `SGSC_RGN_TOS;
    end else if (offset >= `SGSC_OFF_MAC_LO && offset <= `SGSC_OFF_MAC_HI) begin
      region = `SGSC_RGN_MAC;
    end else if (offset >= `SGSC_OFF_USER_LO && offset <= `SGSC_OFF_USER_HI) begin
      region = `SGSC_RGN_USER;
    end else if (offset >= `SGSC_OFF_IND_CTL_LO && offset <= `SGSC_OFF_IND_CTL_HI) begin
      region = `SGSC_RGN_IND_CTL;
    end else if (offset >= `SGSC_OFF_IND_DAT_LO && offset <= `SGSC_OFF_IND_DAT_HI) begin
      region = `SGSC_RGN_IND_DAT;
    end else if (offset >= `SGSC_OFF_TEST_LO && offset <= `SGSC_OFF_TEST_HI) begin
      region = `SGSC_RGN_TEST;
    end
  end
endmodule

// *** logic/sgsc_sync.v ***
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module sgsc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Data.
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end
  assign sync_out = stage2;
endmodule

// *** tb/sgsc_cfg_mem.sv ***
// Behavioural configuration memory answering the loader's byte requests.
`timescale 1ns/1ps
module sgsc_cfg_mem (
  // Clock.
  input wire pclk,
  // Request.
  input wire cfg_read_req,
  input wire [7:0] cfg_addr,
  // Contents and answer delay.
  input wire [23:0] image,
  input wire [3:0] delay,
  // Answer.
  output logic cfg_valid,
  output logic [7:0] cfg_data
);
  logic [3:0] n;
  initial begin
    cfg_valid = 1'b0;
    cfg_data = 8'ha5;
    n = 4'h0;
  end
  // A released data bus toggles every cycle so no stale byte looks valid.
  always @(posedge pclk) begin
    if (!cfg_read_req) begin
      cfg_valid <= 1'b0;
      cfg_data <= ~cfg_data;
      n <= 4'h0;
    end else if (n < delay) begin
      n <= n + 4'h1;
    end else begin
      cfg_valid <= 1'b1;
      cfg_data <= image[8 * cfg_addr[1:0] +: 8];
    end
  end
endmodule

// *** tb/sgsc_top_chk.sv ***
// Port-level assertions for the identity and start control register bank.
`timescale 1ns/1ps
module sgsc_top_chk #(
  parameter [7:0] FAMILY_CODE = 8'h5a,
  parameter [3:0] PART_CODE = 4'h7,
  parameter [2:0] REVISION = 3'h1,
  parameter NUM_PORTS = 3,
  parameter FAST_AGE_CYCLES = 20
) (
  // APB.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Straps and links.
  input wire mode_strap_high,
  input wire mode_strap_low,
  input wire [NUM_PORTS-1:0] link_up,
  // Core controls.
  input wire switch_run,
  input wire alt_backoff,
  input wire pass_flow_ctrl,
  input wire fast_age_active,
  input wire flush_all
);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire wr2 = acc && pwrite && paddr == 32'h8;
  wire nz = mode_strap_high || mode_strap_low;
  reg [7:0] g2;
  reg st;
  reg [15:0] fa_n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g2 <= 8'h44;
      st <= 1'b0;
      fa_n <= 16'h0;
    end else begin
      if (wr2) g2 <= pwdata[7:0];
      if (acc && pwrite && paddr == 32'h4) st <= pwdata[0];
      fa_n <= fast_age_active ? fa_n + 16'h1 : 16'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_family_read: assert property (
    rd && paddr == 32'h0 |-> prdata == {24'h0, FAMILY_CODE}) else $error("family code wrong");
  a_part_read: assert property (
    rd && paddr == 32'h4 |-> prdata[31:1] == {24'h0, PART_CODE, REVISION})
    else $error("part code wrong");
  a_reserved_zero: assert property (
    rd && paddr >= 32'h100 && paddr <= 32'h17c |-> prdata == 32'h0) else $error("reserved not 0");
  a_backoff_write: assert property (
    wr2 |-> ##2 alt_backoff == g2[7]) else $error("back-off bit not applied");
  a_flow_write: assert property (
    wr2 |-> ##2 pass_flow_ctrl == g2[3]) else $error("flow bit not applied");
  a_start_gate: assert property (
    (nz && $stable(st)) [*4] |-> switch_run == st) else $error("run differs from start bit");
  a_drop_flush: assert property (
    |($past(link_up) & ~link_up) |-> ##[1:5] flush_all) else $error("no flush on link drop");
  a_flush_pulse: assert property (
    flush_all |=> !flush_all) else $error("flush longer than one cycle");
  a_fast_age_len: assert property (
    fa_n <= FAST_AGE_CYCLES + 2) else $error("fast aging too long");
  c_flush: cover property (flush_all);
  c_fast: cover property ($fell(fast_age_active));
  c_gctl: cover property (wr2);
endmodule
bind sgsc_top sgsc_top_chk #(.FAMILY_CODE(FAMILY_CODE), .PART_CODE(PART_CODE),
  .REVISION(REVISION), .NUM_PORTS(NUM_PORTS), .FAST_AGE_CYCLES(FAST_AGE_CYCLES))
  sgsc_top_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .mode_strap_high(mode_strap_high), .mode_strap_low(mode_strap_low), .link_up(link_up),
  .switch_run(switch_run), .alt_backoff(alt_backoff), .pass_flow_ctrl(pass_flow_ctrl),
  .fast_age_active(fast_age_active), .flush_all(flush_all));

// *** tb/testbench.sv ***
// Self-checking bench for the identity and start control register bank.
`timescale 1ns/1ps
module testbench;
  // Identity codes are arbitrary.
  localparam [7:0] FAM = 8'h3c;
  localparam [3:0] PC = 4'h9;
  localparam [2:0] RV = 3'h5;
  localparam FA = 20;
  localparam NA = 100;
  logic pclk, presetn, psel, penable, pwrite, mode_strap_high, mode_strap_low, cfg_present;
  logic [31:0] paddr, pwdata, rd;
  logic [23:0] image;
  logic [3:0] delay;
  logic [2:0] link_up;
  wire [31:0] prdata;
  wire [7:0] cfg_addr, cfg_data;
  wire pready, pslverr, cfg_read_req, cfg_valid, switch_run, alt_backoff;
  wire pass_flow_ctrl, fast_age_active, age_tick, flush_all;
  int failures, n_checks, i;
  logic [31:0] ra [5] = '{32'he8, 32'hf8, 32'h100, 32'h17c, 32'h400};
  logic [7:0] gv [3] = '{8'hc4, 8'h4c, 8'h44};
  sgsc_top #(.FAMILY_CODE(FAM), .PART_CODE(PC), .REVISION(RV), .NUM_PORTS(3),
    .FAST_AGE_CYCLES(FA), .NORMAL_AGE_CYCLES(NA), .CFG_WAIT_CYCLES(16)) sgsc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_strap_high(mode_strap_high), .mode_strap_low(mode_strap_low),
    .cfg_read_req(cfg_read_req), .cfg_addr(cfg_addr), .cfg_present(cfg_present),
    .cfg_valid(cfg_valid), .cfg_data(cfg_data), .link_up(link_up), .switch_run(switch_run),
    .alt_backoff(alt_backoff), .pass_flow_ctrl(pass_flow_ctrl),
    .fast_age_active(fast_age_active), .age_tick(age_tick), .flush_all(flush_all));
  sgsc_cfg_mem sgsc_cfg_mem_inst (.pclk(pclk), .cfg_read_req(cfg_read_req),
    .cfg_addr(cfg_addr), .image(image), .delay(delay), .cfg_valid(cfg_valid),
    .cfg_data(cfg_data));
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task boot(input logic [1:0] s, input logic pr, input logic [23:0] im, input logic [3:0] d);
    @(posedge pclk);
    presetn <= 1'b0;
    {mode_strap_high, mode_strap_low} <= s;
    cfg_present <= pr;
    image <= im;
    delay <= d;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(n, rd, e);
  endtask
  task wrun;
    for (i = 0; i < 200 && switch_run !== 1'b1; i++) @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #(25 * 20000);
    failures++;
    summarize;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, link_up} = {4'h0, 64'h0, 3'h7};
    {mode_strap_high, mode_strap_low, cfg_present, image, delay} = 0;
    boot(2'b00, 1'b1, {8'hcc, PC, 4'h0, FAM}, 4'd5);
    wrun;
    chk("run", switch_run, 1);
    rdc("gctl", 32'h8, 32'hcc);
    chk("backoff", alt_backoff, 1);
    chk("passfc", pass_flow_ctrl, 1);
    boot(2'b00, 1'b1, {8'hcc, PC, 4'h0, ~FAM}, 4'd0);
    wrun;
    chk("run", switch_run, 1);
    rdc("gctl", 32'h8, 32'h44);
    boot(2'b00, 1'b0, 24'h0, 4'd0);
    wrun;
    chk("run", switch_run, 1);
    rdc("gctl", 32'h8, 32'h44);
    chk("backoff", alt_backoff, 0);
    chk("passfc", pass_flow_ctrl, 0);
    xfer(1'b1, 32'h0, 8'hff);
    rdc("family", 32'h0, {24'h0, FAM});
    xfer(1'b1, 32'h4, 8'h0f);
    rdc("part", 32'h4, {24'h0, PC, RV, 1'b1});
    foreach (ra[j]) begin
      xfer(1'b1, ra[j], 8'hff);
      rdc("rsvd", ra[j], 32'h0);
      chk("slverr", pslverr, 0);
    end
    foreach (gv[j]) begin
      xfer(1'b1, 32'h8, gv[j]);
      rdc("gctl", 32'h8, {24'h0, gv[j]});
      chk("backoff", alt_backoff, gv[j][7]);
      chk("passfc", pass_flow_ctrl, gv[j][3]);
    end
    xfer(1'b1, 32'h8, 8'h45);
    @(posedge pclk);
    link_up <= 3'h5;
    for (i = 0; i < 10 && flush_all !== 1'b1; i++) @(negedge pclk);
    chk("flush", flush_all, 1);
    for (i = 0; i < 10 && fast_age_active !== 1'b1; i++) @(negedge pclk);
    chk("fast", fast_age_active, 1);
    for (i = 0; i < FA + 20 && fast_age_active === 1'b1; i++) @(negedge pclk);
    chk("fastlen", i >= FA - 2 && i <= FA + 2, 1);
    for (i = 0; i < NA + 20 && age_tick !== 1'b1; i++) @(negedge pclk);
    @(negedge pclk);
    for (i = 1; i < NA + 20 && age_tick !== 1'b1; i++) @(negedge pclk);
    chk("period", i >= NA - 1 && i <= NA + 1, 1);
    @(posedge pclk);
    link_up <= 3'h7;
    for (int s = 1; s < 4; s++) begin
      boot(s[1:0], 1'b1, {8'hcc, PC, 4'h0, FAM}, 4'd0);
      repeat (20) @(negedge pclk);
      chk("run", switch_run, 0);
      rdc("gctl", 32'h8, 32'h44);
      xfer(1'b1, 32'h4, 8'h01);
      wrun;
      chk("run", switch_run, 1);
      xfer(1'b1, 32'h4, 8'h00);
      repeat (10) @(negedge pclk);
      chk("run", switch_run, 0);
    end
    summarize;
  end
endmodule
